// ---- hdl/npw_top.sv ----
// Non-volatile page erase / byte write controller with Avalon-MM slave.
// Assumes one Avalon master that holds each request until waitrequest is low;
// the stall on a launching control write stands for the processor stall.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module npw_top #(
  parameter int ERASE_CLKS = npw_pkg::ERASE_CLKS_DEF,
  parameter int WRITE_CLKS = npw_pkg::WRITE_CLKS_DEF
) (
  input  logic        clk,
  input  logic        sys_rst,
  input  logic [9:0]  address,
  input  logic        read,
  input  logic        write,
  input  logic [31:0] writedata,
  input  logic [3:0]  byteenable,
  output logic [31:0] readdata,
  output logic        waitrequest,
  input  logic        code_rd_en,
  input  logic [6:0]  code_rd_addr,
  output logic [7:0]  code_rd_data,
  output logic        busy
);
  import npw_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WRITE,
    ST_DONE
  } npw_state_type;

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx);
  endfunction : hit

  npw_state_type state_reg;
  logic [6:0]    addr_reg;
  logic [7:0]    data_reg;
  logic [1:0]    ctrl_reg;
  logic [2:0]    page_reg;
  logic [6:0]    target_reg;
  logic [15:0]   cnt_reg;
  logic [4:0]    fill_reg;
  logic          rd_ready_reg;
  logic          accept_wr;
  logic          idle;
  logic          lane0;
  logic          wr_ctrl;
  logic          launch_erase;
  logic          launch_write;
  logic          launch;
  logic          window_open;
  logic          armed;
  logic          mem_we;
  logic [6:0]    mem_waddr;
  logic [7:0]    mem_wdata;
  logic          op_end;
  logic [31:0]   rd_mux;

  assign idle  = (state_reg == ST_IDLE);
  assign lane0 = byteenable[0];
  assign busy  = (state_reg == ST_ERASE) || (state_reg == ST_WRITE);

  assign wr_ctrl = write && lane0 && hit(address, IDX_CTRL);
  // Erase wins when both request bits are set in one write
  assign launch_erase = idle && wr_ctrl && window_open
                        && writedata[ERASE_BIT];
  assign launch_write = idle && wr_ctrl && window_open
                        && !writedata[ERASE_BIT]
                        && writedata[WRITE_BIT];
  assign launch = launch_erase || launch_write;

  // Handshake: launches stall, reads take one wait cycle for the register
  always_comb begin
    waitrequest = 1'b0;
    unique case (state_reg)
      ST_IDLE:  waitrequest = launch || (read && !rd_ready_reg);
      ST_ERASE: waitrequest = 1'b1;
      ST_WRITE: waitrequest = 1'b1;
      ST_DONE:  waitrequest = read;
    endcase
  end

  assign accept_wr = write && !waitrequest;

  npw_unlock u_unlock (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .key_write   (accept_wr && lane0 && hit(address, IDX_KEY)),
    .key_data    (writedata[7:0]),
    .other_write (accept_wr && !hit(address, IDX_KEY)),
    .window_open (window_open),
    .armed       (armed)
  );

  // Bit 7 is not stored, so it reads as zero whatever is written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= ADDR_RESET;
    end else if (accept_wr && lane0 && hit(address, IDX_ADDR)) begin
      addr_reg <= writedata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_reg <= DATA_RESET;
    end else if (accept_wr && lane0 && hit(address, IDX_DATA)) begin
      data_reg <= writedata[7:0];
    end
  end

  assign op_end = (state_reg == ST_ERASE && cnt_reg == 16'(ERASE_CLKS - 1))
               || (state_reg == ST_WRITE && cnt_reg == 16'(WRITE_CLKS - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (launch_erase) begin
            state_reg <= ST_ERASE;
          end else if (launch_write) begin
            state_reg <= ST_WRITE;
          end
        end
        ST_ERASE: begin
          if (op_end) begin
            state_reg <= ST_DONE;
          end
        end
        ST_WRITE: begin
          if (op_end) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 16'h0000;
    end else if (launch || state_reg == ST_DONE) begin
      cnt_reg <= 16'h0000;
    end else if (busy) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Page and byte target frozen at launch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_reg   <= 3'h0;
      target_reg <= ADDR_RESET;
    end else if (launch) begin
      page_reg   <= addr_reg[PAGE_MSB:PAGE_LSB];
      target_reg <= addr_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_reg <= 5'h00;
    end else if (launch_erase) begin
      fill_reg <= 5'h00;
    end else if (state_reg == ST_ERASE && fill_reg != 5'(PAGE_BYTES)) begin
      fill_reg <= fill_reg + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= 2'b00;
    end else if (launch) begin
      ctrl_reg <= {launch_erase, launch_write};
    end else if (state_reg == ST_DONE) begin
      ctrl_reg <= 2'b00;
    end
  end

  // Erase writes one byte per clock, so ERASE_CLKS must be at least a page
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = target_reg;
    mem_wdata = data_reg;
    if (state_reg == ST_ERASE && fill_reg != 5'(PAGE_BYTES)) begin
      mem_we    = 1'b1;
      mem_waddr = {page_reg, fill_reg[3:0]};
      mem_wdata = ERASE_FILL;
    end else if (state_reg == ST_WRITE && cnt_reg == 16'h0000) begin
      mem_we = 1'b1;
    end
  end

  npw_mem u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (code_rd_en),
    .raddr (code_rd_addr),
    .rdata (code_rd_data)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(address, IDX_ADDR)) begin
      rd_mux[ADDR_W-1:0] = addr_reg;
    end else if (hit(address, IDX_CTRL)) begin
      rd_mux[ERASE_BIT] = ctrl_reg[1];
      rd_mux[WRITE_BIT] = ctrl_reg[0];
    end else if (hit(address, IDX_DATA)) begin
      rd_mux[7:0] = data_reg;
    end else if (hit(address, IDX_STATUS)) begin
      rd_mux[ST_OPEN_BIT]  = window_open;
      rd_mux[ST_ARMED_BIT] = armed;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ready_reg <= 1'b0;
      readdata     <= 32'h0000_0000;
    end else begin
      rd_ready_reg <= idle && read && !rd_ready_reg;
      if (idle && read && !rd_ready_reg) begin
        readdata <= rd_mux;
      end
    end
  end

  sequence seq_fill;
    mem_we && mem_wdata == ERASE_FILL && mem_waddr[6:4] == page_reg;
  endsequence

  a_addr_capture: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept_wr && lane0 && hit(address, IDX_ADDR))
      |=> addr_reg == $past(writedata[6:0]))
    else $error("address register not captured");

  a_locked_ignore: assert property (
    @(posedge clk) disable iff (sys_rst)
    (idle && wr_ctrl && !window_open) |-> !waitrequest ##1 idle)
    else $error("locked control write started an operation");

  a_erase_page: assert property (
    @(posedge clk) disable iff (sys_rst)
    launch_erase |=> state_reg == ST_ERASE
                     && page_reg == $past(addr_reg[6:4]))
    else $error("erase page not taken from address");

  a_erase_fill: assert property (
    @(posedge clk) disable iff (sys_rst)
    launch_erase |=> seq_fill [*8])
    else $error("erase did not fill the page");

  a_stall_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    busy |-> waitrequest)
    else $error("stall released during operation");

  a_byte_prog: assert property (
    @(posedge clk) disable iff (sys_rst)
    launch_write |=> mem_we && mem_waddr == $past(addr_reg)
                     && mem_wdata == $past(data_reg))
    else $error("byte write did not program data");

  a_write_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_WRITE && op_end)
      |=> state_reg == ST_DONE && !waitrequest ##1 idle)
    else $error("byte write stall not released");

  a_write_length: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_DONE && $past(state_reg) == ST_WRITE)
      |-> $past(cnt_reg) == 16'(WRITE_CLKS - 1))
    else $error("byte write time wrong");

  // Release of the stall: one cycle of DONE, then idle again
  sequence seq_release;
    state_reg == ST_DONE && !busy ##1 idle;
  endsequence

  sequence seq_launch;
    waitrequest ##1 busy && waitrequest;
  endsequence

  a_erase_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_ERASE && op_end) |=> seq_release)
    else $error("erase stall not released");

  a_erase_length: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_DONE && $past(state_reg) == ST_ERASE)
      |-> $past(cnt_reg) == 16'(ERASE_CLKS - 1))
    else $error("erase time wrong");

  a_launch_stall: assert property (
    @(posedge clk) disable iff (sys_rst)
    launch |-> seq_launch)
    else $error("launching write not stalled");

  a_erase_tail: assert property (
    @(posedge clk) disable iff (sys_rst)
    launch_erase |=> ##8 seq_fill [*8])
    else $error("erase missed the upper half of the page");

  a_erase_stop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_ERASE && fill_reg == 5'(PAGE_BYTES)) |-> !mem_we)
    else $error("erase wrote past the page");

  // Memory is only written while an operation runs
  a_idle_no_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    !busy |-> !mem_we)
    else $error("memory written outside an operation");

  a_zero_ctrl: assert property (
    @(posedge clk) disable iff (sys_rst)
    (idle && wr_ctrl && !writedata[ERASE_BIT] && !writedata[WRITE_BIT])
      |=> idle)
    else $error("zero control write started an operation");

  a_erase_wins: assert property (
    @(posedge clk) disable iff (sys_rst)
    (idle && wr_ctrl && window_open && writedata[ERASE_BIT])
      |=> state_reg == ST_ERASE)
    else $error("erase request did not start an erase");

  a_prog_once: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_WRITE && cnt_reg != 16'h0000) |-> !mem_we)
    else $error("byte programmed more than once");

  a_data_capture: assert property (
    @(posedge clk) disable iff (sys_rst)
    (accept_wr && lane0 && hit(address, IDX_DATA))
      |=> data_reg == $past(writedata[7:0]))
    else $error("data register not captured");

  a_page_frozen: assert property (
    @(posedge clk) disable iff (sys_rst)
    (busy && $past(busy)) |-> $stable(page_reg) && $stable(target_reg))
    else $error("target changed during an operation");

  a_read_answer: assert property (
    @(posedge clk) disable iff (sys_rst)
    (idle && read && !rd_ready_reg) |=> !waitrequest
                                       && readdata == $past(rd_mux))
    else $error("register read not answered in one wait");
endmodule : npw_top

// ---- hdl/npw_pkg.sv ----
// Constants shared by the non-volatile page erase / byte write block.
// Assumes a 200 MHz core clock and a 32-bit Avalon-MM register bus.
//
// Contract
// - The address register holds a 7-bit byte address in bits 6 to 0.
// - A correct unlock opens a write window of three machine cycles.
// - Writing one to control bit 7 erases the selected page.
// - The data area is 8 pages of 16 bytes each.
// - The erased page follows the last value written to the address.
// - The processor stalls on the erase write until the erase ends.
// - Writing one to control bit 6 programs the data byte and stalls.
// - When the byte write ends the stall is released.
// - The data register holds the byte to program; reads use code fetch.
package npw_pkg;
  localparam int CLK_MHZ = 200;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ADDR   = 8'hC6;
  localparam logic [7:0] IDX_KEY    = 8'hC7;
  localparam logic [7:0] IDX_STATUS = 8'hCD;
  localparam logic [7:0] IDX_CTRL   = 8'hCE;
  localparam logic [7:0] IDX_DATA   = 8'hCF;

  localparam int ADDR_W     = 7;
  localparam int PAGE_MSB   = 6;
  localparam int PAGE_LSB   = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES  = 128;
  localparam int ERASE_BIT  = 7;
  localparam int WRITE_BIT  = 6;
  localparam int ST_OPEN_BIT  = 0;
  localparam int ST_ARMED_BIT = 1;

  localparam logic [7:0] KEY_FIRST  = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [7:0] ERASE_FILL = 8'hFF;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Machine cycle and unlock window
  localparam int MC_CLKS     = 4;
  localparam int WINDOW_MCS  = 3;
  localparam int WINDOW_CLKS = MC_CLKS * WINDOW_MCS;

  // Operation times, least times rounded up
  localparam int ERASE_TIME_NS  = 25000;
  localparam int WRITE_TIME_NS  = 10000;
  localparam int ERASE_CLKS_DEF = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_CLKS_DEF = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage : npw_pkg

// ---- hdl/npw_mem.sv ----
// Byte-wide storage of the non-volatile data area.
// One write port for erase and program, one registered code-fetch read port.
`timescale 1ns/1ps
module npw_mem (
  input  logic       clk,
  input  logic       we,
  input  logic [6:0] waddr,
  input  logic [7:0] wdata,
  input  logic       re,
  input  logic [6:0] raddr,
  output logic [7:0] rdata
);
  import npw_pkg::*;

  logic [7:0] cell_mem [MEM_BYTES];

  always_ff @(posedge clk) begin
    if (we) begin
      cell_mem[waddr] <= wdata;
    end
  end

  // Contents are not reset: they model retained storage
  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= cell_mem[raddr];
    end
  end
endmodule : npw_mem

// ---- hdl/npw_unlock.sv ----
// Timed access unlock: AAH then 55H opens a window of three machine cycles.
// Assumes key_write and other_write are one-cycle pulses of accepted writes.
`timescale 1ns/1ps
module npw_unlock (
  input  logic       clk,
  input  logic       sys_rst,
  input  logic       key_write,
  input  logic [7:0] key_data,
  input  logic       other_write,
  output logic       window_open,
  output logic       armed
);
  import npw_pkg::*;

  localparam int WIN_HOLD = WINDOW_CLKS;

  logic       unlock_hit;
  logic       mc_tick;
  logic [2:0] div_reg;
  logic [1:0] mc_reg;
  logic [4:0] age_reg;

  assign unlock_hit = key_write && armed && (key_data == KEY_SECOND);
  assign mc_tick    = (div_reg == 3'(MC_CLKS - 1));

  // Any other write between the two keys breaks the sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else if (key_write) begin
      armed <= !unlock_hit && (key_data == KEY_FIRST);
    end else if (other_write) begin
      armed <= 1'b0;
    end
  end

  // Divider restarts at unlock so the window is exact, not 2 to 3 cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      window_open <= 1'b0;
      div_reg     <= 3'h0;
      mc_reg      <= 2'h0;
    end else if (unlock_hit) begin
      window_open <= 1'b1;
      div_reg     <= 3'h0;
      mc_reg      <= 2'h0;
    end else if (window_open) begin
      div_reg <= mc_tick ? 3'h0 : div_reg + 3'h1;
      if (mc_tick) begin
        mc_reg <= mc_reg + 2'h1;
        if (mc_reg == 2'(WINDOW_MCS - 1)) begin
          window_open <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_reg <= 5'h00;
    end else if (unlock_hit) begin
      age_reg <= 5'h00;
    end else if (window_open) begin
      age_reg <= age_reg + 5'h01;
    end
  end

  a_open_by_key: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(window_open) |-> $past(key_write && armed && key_data == KEY_SECOND))
    else $error("window opened without AAH 55H");

  a_window_length: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(window_open) |-> $past(age_reg) == 5'(WIN_HOLD - 1))
    else $error("unlock window length wrong");

  a_window_bound: assert property (
    @(posedge clk) disable iff (sys_rst)
    window_open |-> age_reg < 5'(WIN_HOLD))
    else $error("unlock window overstayed");

  a_key_cancel: assert property (
    @(posedge clk) disable iff (sys_rst)
    (key_write && key_data != KEY_FIRST && key_data != KEY_SECOND)
      |=> !armed && !$rose(window_open))
    else $error("bad key did not cancel unlock");
endmodule : npw_unlock

// ---- tb/npw_top_tb.sv ----
// Self-checking bench for the page erase / byte write controller.
// Drives the Avalon-MM slave and the code-fetch port directly; no model.
`timescale 1ns/1ps
module npw_top_tb;
  import npw_pkg::*;

  localparam int ECLK = 40;
  localparam int WCLK = 4;

  logic        clk;
  logic        sys_rst;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        code_rd_en;
  logic [6:0]  code_rd_addr;
  logic [7:0]  code_rd_data;
  logic        busy;
  logic [31:0] rd;
  int          wt;
  int          fails;
  int          checks_done;
  int          busy_cnt;

  npw_top #(.ERASE_CLKS(ECLK), .WRITE_CLKS(WCLK)) u_npw_top (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .address      (address),
    .read         (read),
    .write        (write),
    .writedata    (writedata),
    .byteenable   (byteenable),
    .readdata     (readdata),
    .waitrequest  (waitrequest),
    .code_rd_en   (code_rd_en),
    .code_rd_addr (code_rd_addr),
    .code_rd_data (code_rd_data),
    .busy         (busy)
  );

  always #2.5 clk = ~clk;

  // Busy cycles seen at the edges; compared after each operation except the second erase
  always @(posedge clk) begin
    if (sys_rst === 1'b1) begin
      busy_cnt <= 0;
    end else if (busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  task automatic stop_test();
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_mem(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_mem

  task automatic chk_wait(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_wait

  // Request stands until the rising edge that samples waitrequest low
  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [7:0] d);
    address   <= {idx, 2'b00};
    write     <= we;
    read      <= !we;
    writedata <= {24'h000000, d};
    wt = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      wt++;
      if (wt > 1000) begin
        fails++;
        stop_test();
      end
      @(posedge clk);
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rdr(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk_reg(rd, exp);
  endtask : rdr

  task automatic unlock();
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_KEY, KEY_SECOND);
  endtask : unlock

  task automatic code_rd(input logic [6:0] a, input logic [7:0] exp);
    code_rd_en   <= 1'b1;
    code_rd_addr <= a;
    @(posedge clk);
    code_rd_en <= 1'b0;
    @(posedge clk);
    chk_mem(code_rd_data, exp);
  endtask : code_rd

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    address = 10'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    code_rd_en = 1'b0;
    code_rd_addr = 7'h00;
    fails = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdr(IDX_ADDR, 32'h00000000);
    chk_wait(wt, 1);
    rdr(IDX_CTRL, 32'h00000000);
    rdr(IDX_KEY, 32'h00000000);
    rdr(8'h10, 32'h00000000);
    wr(IDX_ADDR, 8'h7F);
    chk_wait(wt, 0);
    rdr(IDX_ADDR, 32'h0000007F);
    // Lane 0 off: write is taken but must not land
    byteenable <= 4'hE;
    wr(IDX_ADDR, 8'h11);
    byteenable <= 4'hF;
    rdr(IDX_ADDR, 32'h0000007F);
    // Erase pages 2 and 3 so later contents are known
    wr(IDX_ADDR, 8'h25);
    unlock();
    wr(IDX_CTRL, 8'h80);
    chk_wait(wt, ECLK + 1);
    chk_wait(busy_cnt, ECLK);
    rdr(IDX_CTRL, 32'h00000000);
    wr(IDX_ADDR, 8'h30);
    unlock();
    wr(IDX_CTRL, 8'h80);
    chk_wait(wt, ECLK + 1);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      code_rd(7'(8'h20 + i), ERASE_FILL);
      code_rd(7'(8'h30 + i), ERASE_FILL);
    end
    // Program one byte
    wr(IDX_ADDR, 8'h23);
    wr(IDX_DATA, 8'h5A);
    rdr(IDX_DATA, 32'h0000005A);
    unlock();
    wr(IDX_CTRL, 8'h40);
    chk_wait(wt, WCLK + 1);
    chk_mem(8'(busy), 8'h00);
    chk_wait(busy_cnt, 2 * ECLK + WCLK);
    code_rd(7'h23, 8'h5A);
    code_rd(7'h22, ERASE_FILL);
    // Protected write with no window
    wr(IDX_ADDR, 8'h24);
    wr(IDX_DATA, 8'hA5);
    wr(IDX_CTRL, 8'h40);
    chk_wait(wt, 0);
    // Wrong second key, then a foreign write between the keys
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_KEY, 8'h12);
    wr(IDX_KEY, KEY_SECOND);
    rdr(IDX_STATUS, 32'h00000000);
    wr(IDX_CTRL, 8'h40);
    chk_wait(wt, 0);
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_ADDR, 8'h24);
    wr(IDX_KEY, KEY_SECOND);
    wr(IDX_CTRL, 8'h40);
    chk_wait(wt, 0);
    // Window opens, then expires after three machine cycles
    unlock();
    bus(1'b0, IDX_STATUS, 8'h00);
    chk_reg(rd & 32'h00000001, 32'h00000001);
    repeat (WINDOW_CLKS + 2) @(posedge clk);
    rdr(IDX_STATUS, 32'h00000000);
    wr(IDX_CTRL, 8'h40);
    chk_wait(wt, 0);
    unlock();
    wr(IDX_CTRL, 8'h00);
    chk_wait(wt, 0);
    code_rd(7'h24, ERASE_FILL);
    // Erase follows the latest address write, page of bits 6 to 4 only
    wr(IDX_ADDR, 8'h24);
    wr(IDX_ADDR, 8'h3F);
    unlock();
    wr(IDX_CTRL, 8'h80);
    chk_wait(wt, ECLK + 1);
    chk_wait(busy_cnt, 3 * ECLK + WCLK);
    code_rd(7'h23, 8'h5A);
    code_rd(7'h3F, ERASE_FILL);
    // Both request bits set: the erase runs, not the byte write
    unlock();
    wr(IDX_CTRL, 8'hC0);
    chk_wait(wt, ECLK + 1);
    chk_wait(busy_cnt, 4 * ECLK + WCLK);
    code_rd(7'h23, 8'h5A);
    stop_test();
  end
endmodule : npw_top_tb
